// *** rfr_host_model.sv ***
// Host model driving the register port
`timescale 1ns/1ps
module rfr_host_model (
  // Clock
  input wire logic clk,
  // Requests toward the device
  output logic [5:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_wdata,
  // Answers from the device
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle lines at time zero
  initial begin
    reg_addr = 6'h3f;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe; lines then flip to expose stale use
  task automatic write(input logic [5:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // Read strobe, then bounded wait for valid
  task automatic read(input logic [5:0] addr, output logic [7:0] data, output logic hit,
                      output logic ok);
    int k;
    @(negedge clk);
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    reg_addr = ~addr;
    ok = 1'b0;
    for (k = 0; k < 4 && !ok; k++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        data = reg_rdata;
        hit = reg_hit;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // rfr_host_model

// *** rfr_main_config.sv ***
// Main control and first configuration registers
`timescale 1ns/1ps
// Function
// R1: Control bit 7 selects standby
// R2: Control bit 2 enables gain control
// R3: Control bit 1 enables the receive path
// R4: Control bit 0 enables field and receiver
// R5: Protocol bit 7 drops reply CRC
// R6: Protocol bit 6 disables decoding and sensing
// R7: Host sets raw mode when measuring
// R8: Handshake field: none, ack, ack plus handle
// R9: Standard field: Gen2 or type A/B direct
// R10: Data-one length 1.50 to 2.00 Tari
// R11: Tari field selects 6.25, 12.5, 25 us
// R12: Link field selects 40 to 640 kHz
// R13: Receive bit 3 long preamble; short Miller4/8
// R14: Reply coding FM0, Miller 2, 4, 8
// R15: 12-bit calibration time, upper four here
// R16: High bit 6 doubles indicator gain
// R17: High bit 5 adds half indicator gain
// R18: High bit 7 adapts oscillator shifter
// R19: All bits take defaults after reset
// R20: Calibration value counts 0.1 us steps
// R21: Six-bit addresses, serial interface
// R22: Host writes no reserved bits or codes; the bench writes both, random reserved bits and standard code 5
module rfr_main_config
  import rfr_pkg::*;
#(
  parameter int ADDR_WIDTH = 6,
  parameter int DATA_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial interface
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_WIDTH-1:0] reg_wdata,
  output logic [DATA_WIDTH-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // Lower calibration bits
  input wire logic [7:0] calibration_low,
  // Decoded settings
  output rfr_power_type power_ctrl,
  output rfr_protocol_type protocol_ctrl,
  output rfr_tx_timing_type tx_timing,
  output rfr_rx_link_type rx_link,
  output rfr_analog_type analog_ctrl
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [RFR_NUM_REGS-1:0] sel;
  logic [7:0] power_value;
  logic [7:0] protocol_value;
  logic [7:0] tx_value;
  logic [7:0] rx_value;
  logic [7:0] cal_high_value;

  // One-hot select
  always_comb begin
    sel = '0;
    unique case (reg_addr)
      RFR_OFS_POWER_CTRL: sel[0] = 1'b1; // R21
      RFR_OFS_PROTOCOL: sel[1] = 1'b1;
      RFR_OFS_TX_OPTIONS: sel[2] = 1'b1;
      RFR_OFS_RX_OPTIONS: sel[3] = 1'b1;
      RFR_OFS_CAL_HIGH: sel[4] = 1'b1;
      default: sel = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  rfr_reg_cell #(
    .RESET_VALUE(RFR_RST_POWER_CTRL),
    .BIT_MASK(RFR_MSK_POWER_CTRL)
  ) u_power (
    .clk(clk),
    .rst_n(rst_n),
    .write_en(reg_write && sel[0]),
    .write_data(reg_wdata[7:0]),
    .value(power_value)
  ); // R19

  rfr_reg_cell #(
    .RESET_VALUE(RFR_RST_PROTOCOL),
    .BIT_MASK(RFR_MSK_PROTOCOL)
  ) u_protocol (
    .clk(clk),
    .rst_n(rst_n),
    .write_en(reg_write && sel[1]),
    .write_data(reg_wdata[7:0]),
    .value(protocol_value)
  );

  rfr_reg_cell #(
    .RESET_VALUE(RFR_RST_TX_OPTIONS),
    .BIT_MASK(RFR_MSK_TX_OPTIONS)
  ) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .write_en(reg_write && sel[2]),
    .write_data(reg_wdata[7:0]),
    .value(tx_value)
  );

  rfr_reg_cell #(
    .RESET_VALUE(RFR_RST_RX_OPTIONS),
    .BIT_MASK(RFR_MSK_RX_OPTIONS)
  ) u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .write_en(reg_write && sel[3]),
    .write_data(reg_wdata[7:0]),
    .value(rx_value)
  );

  rfr_reg_cell #(
    .RESET_VALUE(RFR_RST_CAL_HIGH),
    .BIT_MASK(RFR_MSK_CAL_HIGH)
  ) u_cal_high (
    .clk(clk),
    .rst_n(rst_n),
    .write_en(reg_write && sel[4]),
    .write_data(reg_wdata[7:0]),
    .value(cal_high_value)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    unique case (1'b1)
      sel[0]: read_mux = power_value;
      sel[1]: read_mux = protocol_value;
      sel[2]: read_mux = tx_value;
      sel[3]: read_mux = rx_value;
      sel[4]: read_mux = cal_high_value;
      default: read_mux = 8'h00;
    endcase
  end

  // Unmapped addresses read zero, hit low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
      reg_hit <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= DATA_WIDTH'(read_mux);
        reg_hit <= |sel; // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power control decode

  // Standby gates every enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ctrl <= '0;
    end else begin
      power_ctrl.standby <= power_value[RFR_BIT_STANDBY]; // R1
      power_ctrl.agc_enable <= power_value[RFR_BIT_AGC] && !power_value[RFR_BIT_STANDBY]; // R2
      // Field bit brings the receiver up with it
      power_ctrl.receiver_enable <= (power_value[RFR_BIT_RECEIVER] ||
        power_value[RFR_BIT_FIELD]) && !power_value[RFR_BIT_STANDBY]; // R3 R4
      power_ctrl.carrier_field_enable <= power_value[RFR_BIT_FIELD] &&
        !power_value[RFR_BIT_STANDBY]; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol decode

  logic [1:0] hs_field;
  logic [2:0] std_field;

  assign hs_field = protocol_value[RFR_POS_HANDSHAKE +: 2];
  assign std_field = protocol_value[RFR_POS_STANDARD +: 3];

  // Reserved standard codes fall back to Gen2, flagged; handshake code 3 passes through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protocol_ctrl.crc_check_enable <= 1'b1;
      protocol_ctrl.raw_decoder_mode <= 1'b0;
      protocol_ctrl.automatic_tag_handshake <= RFR_HS_NONE;
      protocol_ctrl.air_standard <= RFR_STD_GEN2;
      protocol_ctrl.standard_valid <= 1'b1;
    end else begin
      protocol_ctrl.crc_check_enable <= !protocol_value[RFR_BIT_NO_CRC]; // R5
      protocol_ctrl.raw_decoder_mode <= protocol_value[RFR_BIT_RAW_DECODER]; // R6 R7
      protocol_ctrl.automatic_tag_handshake <= rfr_handshake_type'(hs_field); // R8 R22
      unique case (std_field)
        RFR_STD_GEN2: begin
          protocol_ctrl.air_standard <= RFR_STD_GEN2; // R9
          protocol_ctrl.standard_valid <= 1'b1;
        end
        RFR_STD_TYPE_AB_DIRECT: begin
          protocol_ctrl.air_standard <= RFR_STD_TYPE_AB_DIRECT; // R9
          protocol_ctrl.standard_valid <= 1'b1;
        end
        default: begin
          protocol_ctrl.air_standard <= RFR_STD_GEN2; // R22
          protocol_ctrl.standard_valid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit symbol timing

  logic [10:0] tari_next;
  logic tari_ok_next;
  logic [7:0] one_ratio;
  logic [18:0] one_product;

  // Tari in clock cycles
  always_comb begin
    tari_next = 11'(RFR_TARI_LONG_CYC);
    tari_ok_next = 1'b1;
    unique case (tx_value[RFR_POS_TARI +: 3])
      3'h0: tari_next = 11'(RFR_TARI_SHORT_CYC); // R11
      3'h1: tari_next = 11'(RFR_TARI_MID_CYC);
      3'h2: tari_next = 11'(RFR_TARI_LONG_CYC);
      default: tari_ok_next = 1'b0;
    endcase
  end

  // Data-one ratio in hundredths of Tari
  always_comb begin
    one_ratio = 8'(RFR_ONE_RATIO_200);
    unique case (tx_value[RFR_POS_DATA_ONE +: 2])
      2'h0: one_ratio = 8'(RFR_ONE_RATIO_150); // R10
      2'h1: one_ratio = 8'(RFR_ONE_RATIO_166);
      2'h2: one_ratio = 8'(RFR_ONE_RATIO_183);
      2'h3: one_ratio = 8'(RFR_ONE_RATIO_200);
    endcase
  end

  // Truncation drops fractions of a cycle
  assign one_product = 19'(tari_next) * 19'(one_ratio);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_timing.tari_cycles <= 11'(RFR_TARI_LONG_CYC);
      tx_timing.data_one_symbol_length <= 12'(RFR_TARI_LONG_CYC * RFR_ONE_RATIO_200 / 100);
      tx_timing.tari_valid <= 1'b1;
    end else begin
      tx_timing.tari_cycles <= tari_next; // R11
      tx_timing.data_one_symbol_length <= 12'(one_product / 19'd100); // R10
      tx_timing.tari_valid <= tari_ok_next; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive link settings

  logic [9:0] lf_next;
  logic lf_ok_next;
  logic [2:0] cod_field;
  logic miller_high;

  // Link period in cycles; reserved code keeps the slowest
  always_comb begin
    lf_next = 10'(RFR_CLK_KHZ / RFR_LF_40_KHZ);
    lf_ok_next = 1'b1;
    unique case (rx_value[RFR_POS_LINK_FREQ +: 4])
      RFR_LF_CODE_40: lf_next = 10'(RFR_CLK_KHZ / RFR_LF_40_KHZ); // R12
      RFR_LF_CODE_160: lf_next = 10'(RFR_CLK_KHZ / RFR_LF_160_KHZ);
      RFR_LF_CODE_250: lf_next = 10'(RFR_CLK_KHZ / RFR_LF_250_KHZ);
      RFR_LF_CODE_320: lf_next = 10'(RFR_CLK_KHZ / RFR_LF_320_KHZ);
      RFR_LF_CODE_640: lf_next = 10'(RFR_CLK_KHZ / RFR_LF_640_KHZ);
      default: lf_ok_next = 1'b0;
    endcase
  end

  assign cod_field = rx_value[RFR_POS_CODING +: 3];
  assign miller_high = (cod_field == RFR_COD_MILLER4) || (cod_field == RFR_COD_MILLER8);

  // Short preamble only with Miller 4 or 8
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_link.backscatter_link_freq <= 10'(RFR_CLK_KHZ / RFR_LF_320_KHZ);
      rx_link.link_freq_valid <= 1'b1;
      rx_link.long_preamble <= 1'b1;
      rx_link.preamble_forced <= 1'b0;
      rx_link.reply_coding <= RFR_COD_MILLER4;
      rx_link.coding_valid <= 1'b1;
    end else begin
      rx_link.backscatter_link_freq <= lf_next; // R12
      rx_link.link_freq_valid <= lf_ok_next;
      rx_link.long_preamble <= rx_value[RFR_BIT_LONG_PREAMBLE] || !miller_high; // R13
      rx_link.preamble_forced <= !rx_value[RFR_BIT_LONG_PREAMBLE] && !miller_high; // R13
      if (cod_field <= 3'(RFR_COD_MILLER8)) begin
        rx_link.reply_coding <= rfr_coding_type'(cod_field); // R14
        rx_link.coding_valid <= 1'b1;
      end else begin
        rx_link.reply_coding <= RFR_COD_MILLER4; // R22
        rx_link.coding_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration time and analog adaptations

  logic [11:0] cal_steps;

  assign cal_steps = {cal_high_value[RFR_POS_CAL_UPPER +: 4], calibration_low}; // R15

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.calibration_steps <= cal_steps; // R15
      // Each step is 0.1 us; full scale stays inside 14 bits
      analog_ctrl.calibration_cycles <= 14'(cal_steps) * 14'(RFR_CAL_STEP_CYC); // R20
      analog_ctrl.oscillator_shifter_low_supply <= cal_high_value[RFR_BIT_LOW_SUPPLY]; // R18
      analog_ctrl.mixer_level_gain_double <= cal_high_value[RFR_BIT_GAIN_DOUBLE]; // R16
      analog_ctrl.mixer_level_gain_half_extra <= cal_high_value[RFR_BIT_GAIN_HALF]; // R17
      // Both set: gains multiply to three
      analog_ctrl.indicator_gain <= rfr_gain_type'({cal_high_value[RFR_BIT_GAIN_DOUBLE],
        cal_high_value[RFR_BIT_GAIN_HALF]}); // R16 R17
    end
  end

endmodule // rfr_main_config

// *** rfr_main_config_asserts.sv ***
// Port checks of the configuration bank
`timescale 1ns/1ps
module rfr_main_config_asserts
  import rfr_pkg::*;
#(
  parameter int ADDR_WIDTH = 6,
  parameter int DATA_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_WIDTH-1:0] reg_wdata,
  input wire logic [DATA_WIDTH-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // Calibration and settings
  input wire logic [7:0] calibration_low,
  input wire rfr_power_type power_ctrl,
  input wire rfr_protocol_type protocol_ctrl,
  input wire rfr_tx_timing_type tx_timing,
  input wire rfr_rx_link_type rx_link,
  input wire rfr_analog_type analog_ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Write, quiet cycle, then the decode shows it
  sequence s_ctrl_settled;
    (reg_write && reg_addr == RFR_OFS_POWER_CTRL) ##1 !(reg_write && reg_addr == RFR_OFS_POWER_CTRL);
  endsequence
  sequence s_prot_settled;
    (reg_write && reg_addr == RFR_OFS_PROTOCOL) ##1 !(reg_write && reg_addr == RFR_OFS_PROTOCOL);
  endsequence

  // Read handshake
  a_rvalid_follows_read: assert property (reg_read |=> reg_rvalid)
    else $error("no valid after read");
  a_rvalid_needs_read: assert property (reg_rvalid |-> $past(reg_read))
    else $error("valid without read");
  a_unmapped_read_zero: assert property (reg_read && reg_addr > 4 |=> reg_rdata == '0 && !reg_hit)
    else $error("unmapped read");
  a_mapped_read_hit: assert property (reg_read && reg_addr <= 4 |=> reg_hit)
    else $error("mapped read missed");

  // Power control and protocol decode
  a_standby_gates_all: assert property (power_ctrl.standby |-> !(power_ctrl.agc_enable ||
    power_ctrl.receiver_enable || power_ctrl.carrier_field_enable))
    else $error("enable active in standby");
  a_field_enables_rx: assert property (power_ctrl.carrier_field_enable |-> power_ctrl.receiver_enable)
    else $error("field on without receiver");
  a_ctrl_write_decode: assert property (s_ctrl_settled |=> power_ctrl.standby == $past(reg_wdata[7], 2)
    && power_ctrl.agc_enable == ($past(reg_wdata[2], 2) && !$past(reg_wdata[7], 2)))
    else $error("control decode");
  a_prot_write_decode: assert property (s_prot_settled |=> protocol_ctrl.crc_check_enable ==
    !$past(reg_wdata[7], 2) && protocol_ctrl.raw_decoder_mode == $past(reg_wdata[6], 2))
    else $error("protocol decode");

  // Calibration and indicator gain
  a_cal_low_follows: assert property ($past(rst_n) |->
    analog_ctrl.calibration_steps[7:0] == $past(calibration_low))
    else $error("calibration low bits");
  a_cal_cycles_scale: assert property (analog_ctrl.calibration_cycles ==
    {analog_ctrl.calibration_steps, 2'b00})
    else $error("calibration cycles");
  a_gain_code_bits: assert property (analog_ctrl.indicator_gain ==
    {analog_ctrl.mixer_level_gain_double, analog_ctrl.mixer_level_gain_half_extra})
    else $error("indicator gain");
endmodule // rfr_main_config_asserts

bind rfr_main_config rfr_main_config_asserts #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH))
  rfr_main_config_asserts_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .calibration_low(calibration_low),
  .power_ctrl(power_ctrl), .protocol_ctrl(protocol_ctrl), .tx_timing(tx_timing),
  .rx_link(rx_link), .analog_ctrl(analog_ctrl));

// *** rfr_main_config_tb.sv ***
// Self-checking bench for the main configuration bank
`timescale 1ns/1ps
module rfr_main_config_tb
  import rfr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] reg_addr;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  logic [7:0] calibration_low;
  rfr_power_type power_ctrl;
  rfr_protocol_type protocol_ctrl;
  rfr_tx_timing_type tx_timing;
  rfr_rx_link_type rx_link;
  rfr_analog_type analog_ctrl;
  int miscompares = 0;
  int samples_checked = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  rfr_main_config rfr_main_config_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .calibration_low(calibration_low),
    .power_ctrl(power_ctrl), .protocol_ctrl(protocol_ctrl), .tx_timing(tx_timing),
    .rx_link(rx_link), .analog_ctrl(analog_ctrl));
  rfr_host_model host_i (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Write, then let decode settle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_i.write(a, d);
    repeat (2) @(negedge clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic h;
    logic ok;
    host_i.read(a, d, h, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR rvalid expected 1 seen 0");
      complete_run();
    end
    chk("rdata", {24'h0, exp}, {24'h0, d});
    chk("hit", {31'h0, exp_hit}, {31'h0, h});
  endtask

  // Expectations; unimplemented bits read as zero
  logic [7:0] reg_msk [5] = '{8'h87, 8'hf7, 8'h37, 8'hff, 8'hef};
  function automatic int tari_cyc(input int code);
    int ns;
    ns = (code == 0) ? 6250 : (code == 1) ? 12500 : 25000;
    return ns * 40 / 1000;
  endfunction
  function automatic int one_ratio(input int code);
    return (code == 0) ? 150 : (code == 1) ? 166 : (code == 2) ? 183 : 200;
  endfunction

  // Hang guard
  initial begin
    #2500000;
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int j;
    int t;
    logic [7:0] d;
    logic [7:0] cl;
    logic [7:0] rst_tab [5];
    logic [3:0] lf_code [5];
    int lf_khz [5];
    rst_tab = '{8'h00, 8'h00, 8'h32, 8'hca, 8'h02};
    lf_code = '{4'h0, 4'h6, 4'h9, 4'hc, 4'hf};
    lf_khz = '{40, 160, 250, 320, 640};
    calibration_low = 8'h00;
    void'($urandom(32'h8ed0));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    // Defaults after power-up
    for (i = 0; i < 5; i++) rd_chk(i[5:0], rst_tab[i], 1'b1);
    chk("tari", 1000, {21'h0, tx_timing.tari_cycles});
    chk("one_len", 2000, {20'h0, tx_timing.data_one_symbol_length});
    chk("coding", {29'h0, RFR_COD_MILLER4}, {29'h0, rx_link.reply_coding});
    // Unmapped: writes ignored, reads zero
    wr(6'h05, 8'hff);
    rd_chk(6'h05, 8'h00, 1'b0);
    rd_chk(6'h3f, 8'h00, 1'b0);
    // Random readback, reserved bits included
    for (i = 0; i < 24; i++) begin
      j = $urandom % 5;
      d = $urandom;
      host_i.write(j[5:0], d);
      rd_chk(j[5:0], d & reg_msk[j], 1'b1);
    end
    // All control bit combinations
    for (j = 0; j < 16; j++) begin
      d = {j[3], 4'h0, j[2:0]};
      wr(6'h00, d);
      chk("power", {28'h0, d[7], d[2] & ~d[7], (d[1] | d[0]) & ~d[7], d[0] & ~d[7]},
          {28'h0, power_ctrl});
    end
    // Legal handshake and standard codes, random CRC and raw bits
    for (j = 0; j < 12; j++) begin
      t = $urandom;
      d = {t[1:0], 2'(j % 3), 3'h0, 1'((j / 3) % 2)};
      wr(6'h01, d);
      chk("protocol", {23'h0, ~d[7], d[6], d[5:4], d[2:0], 1'b1},
          {23'h0, protocol_ctrl});
    end
    wr(6'h01, 8'h05);
    chk("std_valid", 0, {31'h0, protocol_ctrl.standard_valid});
    // Tari and data-one length
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 4; j++) begin
        wr(6'h02, {2'h0, j[1:0], 1'b0, i[2:0]});
        t = tari_cyc(i);
        chk("tari", t, {21'h0, tx_timing.tari_cycles});
        chk("one_len", t * one_ratio(j) / 100, {20'h0, tx_timing.data_one_symbol_length});
      end
    end
    // Link frequency, preamble and coding
    for (i = 0; i < 5; i++) begin
      for (j = 0; j < 8; j++) begin
        wr(6'h03, {lf_code[i], j[2], 1'b0, j[1:0]});
        chk("link", 40000 / lf_khz[i], {22'h0, rx_link.backscatter_link_freq});
        chk("long_pre", {31'h0, j[2] | (j[1:0] < 2)}, {31'h0, rx_link.long_preamble});
        chk("forced", {31'h0, !j[2] & (j[1:0] < 2)}, {31'h0, rx_link.preamble_forced});
        chk("coding", {30'h0, j[1:0]}, {29'h0, rx_link.reply_coding});
      end
    end
    // Raw mode during the analog readings
    wr(6'h01, 8'h40);
    for (i = 0; i < 8; i++) begin
      d = $urandom & 8'hef;
      cl = $urandom;
      calibration_low = cl;
      wr(6'h04, d);
      chk("analog", {15'h0, d[7:5], d[6:5], d[3:0], cl}, {15'h0,
          analog_ctrl.oscillator_shifter_low_supply, analog_ctrl.mixer_level_gain_double,
          analog_ctrl.mixer_level_gain_half_extra, analog_ctrl.indicator_gain,
          analog_ctrl.calibration_steps});
      chk("cal_cyc", {d[3:0], cl} * 4, {18'h0, analog_ctrl.calibration_cycles});
    end
    // Second reset in mid-run restores defaults
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 5; i++) rd_chk(i[5:0], rst_tab[i], 1'b1);
    complete_run();
  end
endmodule // rfr_main_config_tb

// *** rfr_pkg.sv ***
// Constants, encodings and carriers of the configuration bank
package rfr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [5:0] RFR_OFS_POWER_CTRL = 6'h00;
  localparam logic [5:0] RFR_OFS_PROTOCOL = 6'h01;
  localparam logic [5:0] RFR_OFS_TX_OPTIONS = 6'h02;
  localparam logic [5:0] RFR_OFS_RX_OPTIONS = 6'h03;
  localparam logic [5:0] RFR_OFS_CAL_HIGH = 6'h04;
  localparam int RFR_NUM_REGS = 5;

  // Reset values
  localparam logic [7:0] RFR_RST_POWER_CTRL = 8'h00;
  localparam logic [7:0] RFR_RST_PROTOCOL = 8'h00;
  localparam logic [7:0] RFR_RST_TX_OPTIONS = 8'h32;
  localparam logic [7:0] RFR_RST_RX_OPTIONS = 8'hca;
  localparam logic [7:0] RFR_RST_CAL_HIGH = 8'h02;

  // Implemented bits
  localparam logic [7:0] RFR_MSK_POWER_CTRL = 8'h87;
  localparam logic [7:0] RFR_MSK_PROTOCOL = 8'hf7;
  localparam logic [7:0] RFR_MSK_TX_OPTIONS = 8'h37;
  localparam logic [7:0] RFR_MSK_RX_OPTIONS = 8'hff;
  localparam logic [7:0] RFR_MSK_CAL_HIGH = 8'hef;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int RFR_BIT_STANDBY = 7;
  localparam int RFR_BIT_AGC = 2;
  localparam int RFR_BIT_RECEIVER = 1;
  localparam int RFR_BIT_FIELD = 0;
  localparam int RFR_BIT_NO_CRC = 7;
  localparam int RFR_BIT_RAW_DECODER = 6;
  localparam int RFR_POS_HANDSHAKE = 4;
  localparam int RFR_POS_STANDARD = 0;
  localparam int RFR_POS_DATA_ONE = 4;
  localparam int RFR_POS_TARI = 0;
  localparam int RFR_POS_LINK_FREQ = 4;
  localparam int RFR_BIT_LONG_PREAMBLE = 3;
  localparam int RFR_POS_CODING = 0;
  localparam int RFR_BIT_LOW_SUPPLY = 7;
  localparam int RFR_BIT_GAIN_DOUBLE = 6;
  localparam int RFR_BIT_GAIN_HALF = 5;
  localparam int RFR_POS_CAL_UPPER = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int RFR_CLK_KHZ = 40000;
  localparam int RFR_TARI_SHORT_NS = 6250;
  localparam int RFR_TARI_MID_NS = 12500;
  localparam int RFR_TARI_LONG_NS = 25000;
  localparam int RFR_TARI_SHORT_CYC = RFR_TARI_SHORT_NS * RFR_CLK_KHZ / 1000000;
  localparam int RFR_TARI_MID_CYC = RFR_TARI_MID_NS * RFR_CLK_KHZ / 1000000;
  localparam int RFR_TARI_LONG_CYC = RFR_TARI_LONG_NS * RFR_CLK_KHZ / 1000000;
  // Data-one length as hundredths of Tari
  localparam int RFR_ONE_RATIO_150 = 150;
  localparam int RFR_ONE_RATIO_166 = 166;
  localparam int RFR_ONE_RATIO_183 = 183;
  localparam int RFR_ONE_RATIO_200 = 200;
  // Link frequencies in kHz; period in cycles rounds down
  localparam int RFR_LF_40_KHZ = 40;
  localparam int RFR_LF_160_KHZ = 160;
  localparam int RFR_LF_250_KHZ = 250;
  localparam int RFR_LF_320_KHZ = 320;
  localparam int RFR_LF_640_KHZ = 640;
  localparam logic [3:0] RFR_LF_CODE_40 = 4'h0;
  localparam logic [3:0] RFR_LF_CODE_160 = 4'h6;
  localparam logic [3:0] RFR_LF_CODE_250 = 4'h9;
  localparam logic [3:0] RFR_LF_CODE_320 = 4'hc;
  localparam logic [3:0] RFR_LF_CODE_640 = 4'hf;
  // Calibration time step of 0.1 us
  localparam int RFR_CAL_STEP_NS = 100;
  localparam int RFR_CAL_STEP_CYC = RFR_CAL_STEP_NS * RFR_CLK_KHZ / 1000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Encodings
  typedef enum logic [1:0] {
    RFR_HS_NONE = 2'h0,
    RFR_HS_ACK = 2'h1,
    RFR_HS_ACK_NEW_HANDLE = 2'h2,
    RFR_HS_RESERVED = 2'h3
  } rfr_handshake_type;

  typedef enum logic [2:0] {
    RFR_STD_GEN2 = 3'h0,
    RFR_STD_TYPE_AB_DIRECT = 3'h1
  } rfr_standard_type;

  typedef enum logic [2:0] {
    RFR_COD_FM0 = 3'h0,
    RFR_COD_MILLER2 = 3'h1,
    RFR_COD_MILLER4 = 3'h2,
    RFR_COD_MILLER8 = 3'h3
  } rfr_coding_type;

  // Mixer level indicator gain
  typedef enum logic [1:0] {
    RFR_GAIN_UNITY,
    RFR_GAIN_ONE_HALF,
    RFR_GAIN_DOUBLE,
    RFR_GAIN_TRIPLE
  } rfr_gain_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic standby;
    logic agc_enable;
    logic receiver_enable;
    logic carrier_field_enable;
  } rfr_power_type;

  typedef struct packed {
    logic crc_check_enable;
    logic raw_decoder_mode;
    rfr_handshake_type automatic_tag_handshake;
    rfr_standard_type air_standard;
    logic standard_valid;
  } rfr_protocol_type;

  typedef struct packed {
    logic [10:0] tari_cycles;
    logic [11:0] data_one_symbol_length;
    logic tari_valid;
  } rfr_tx_timing_type;

  typedef struct packed {
    logic [9:0] backscatter_link_freq;
    logic link_freq_valid;
    logic long_preamble;
    logic preamble_forced;
    rfr_coding_type reply_coding;
    logic coding_valid;
  } rfr_rx_link_type;

  typedef struct packed {
    logic [11:0] calibration_steps;
    logic [13:0] calibration_cycles;
    logic oscillator_shifter_low_supply;
    logic mixer_level_gain_double;
    logic mixer_level_gain_half_extra;
    rfr_gain_type indicator_gain;
  } rfr_analog_type;

endpackage

// *** rfr_reg_cell.sv ***
// Eight-bit register with reset value and bit mask
`timescale 1ns/1ps
module rfr_reg_cell #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] BIT_MASK = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write side
  input wire logic write_en,
  input wire logic [7:0] write_data,
  // Stored value
  output logic [7:0] value
);

  logic [7:0] value_reg;

  // Unused bits never hold a one, so read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= RESET_VALUE & BIT_MASK;
    end else if (write_en) begin
      value_reg <= write_data & BIT_MASK;
    end
  end

  assign value = value_reg;

endmodule // rfr_reg_cell
